/* File: lpm_pkg.sv */
// Shared constants and types of the low-power sequencer.
// Assumes one 200 MHz clock and an Avalon-MM slave with byte addresses.
package lpm_pkg;

  // -----------------------------------------------------------------
  // Register map
  // -----------------------------------------------------------------
  localparam int LPM_AW = 4; // Byte address width
  localparam logic [3:0] LPM_OFS_BRK = 4'h0; // break_exit_status
  localparam logic [3:0] LPM_OFS_CAUSE = 4'h4; // reset_cause_status
  localparam logic [3:0] LPM_OFS_BFC = 4'h8; // break_flag_control
  localparam logic [3:0] LPM_OFS_CFG = 4'hc; // Recovery and watchdog options

  // -----------------------------------------------------------------
  // Field positions
  // -----------------------------------------------------------------
  localparam int LPM_BIT_BRK = 1; // break_exit_flag
  localparam int LPM_BIT_BREAK_FLAG_CLEAR_ENABLE = 7; // break_flag_clear_enable
  localparam int LPM_BIT_SHORT_RECOVERY_SELECT = 0; // short_recovery_select
  localparam int LPM_BIT_WDIS = 1; // watchdog_disable
  localparam int LPM_BIT_POR = 7; // Cause flags
  localparam int LPM_BIT_PIN = 6;
  localparam int LPM_BIT_WDOG = 5;
  localparam int LPM_BIT_OPC = 4;
  localparam int LPM_BIT_FETCH = 3;
  localparam int LPM_BIT_LV = 1;

  // -----------------------------------------------------------------
  // Reset values and timing counts
  // -----------------------------------------------------------------
  localparam logic [7:0] LPM_CAUSE_RST = 8'h80; // Power-on flag only
  localparam logic LPM_BREAK_FLAG_CLEAR_ENABLE_RST = 1'b0;
  localparam logic LPM_SHORT_RECOVERY_SELECT_RST = 1'b0; // Full recovery by default
  localparam logic LPM_WDIS_RST = 1'b0;
  localparam int LPM_REC_LONG = 4096; // Reference clock cycles
  localparam int LPM_REC_SHORT = 32;
  localparam int LPM_CW = 12; // Recovery counter width

  // -----------------------------------------------------------------
  // Types
  // -----------------------------------------------------------------
  typedef enum logic [1:0] {LPM_RUN, LPM_WAIT, LPM_STOP, LPM_RECOVER}
    lpm_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [LPM_AW-1:0] address;
    logic [31:0] writedata;
  } lpm_avs_req_t;

  typedef struct packed {
    logic wake_irq; // Enabled interrupt from an active module
    logic break_irq; // Break interrupt request
    logic break_state; // CPU sits in break state
    logic wait_exec; // Light-sleep instruction executed
    logic stop_exec; // Deep-sleep instruction executed
  } lpm_cpu_t;

  typedef struct packed {
    logic pin; // External reset pin
    logic wdog; // Watchdog timeout
    logic opcode; // Bad opcode
    logic fetch; // Access to an unmapped address
    logic opfetch; // Qualifier: that access was an opcode fetch
    logic lv; // Low-voltage detect
  } lpm_rst_src_t;

endpackage : lpm_pkg

/* File: lpm_sequencer.sv */
// Low-power mode sequencer with break and reset-cause status.
// Assumes CPU, break, watchdog and reset sources share mclk.
//
// Functional notes
// - Light-sleep gates CPU clocks, peripherals keep running
// - Light-sleep interrupt wakes, stacking next cycle
// - Reset or break also ends light-sleep
// - Break in light-sleep sets break-exit flag
// - Watchdog runs in light-sleep unless disabled
// - Deep-sleep clears counter, stops core/reference clocks
// - Interrupt ends deep-sleep; stack after recovery
// - Reset or break also ends deep-sleep
// - Recovery 4096 cycles, or 32 when short
// - Break in deep-sleep sets break-exit flag
// - Counter held clear until recovery, then counts
// - Writing zero clears the break-exit flag
// - Break-exit flag one means break ended sleep
// - Reset-cause flags clear when register read
// - Power-on reset sets power-on cause flag
// - Each reset source sets its own flag
// - Fetch flag only for opcode fetch resets
// - Clear-enable bit gates clearing in break state
// - Either sleep instruction clears interrupt mask
`timescale 1ns/10ps
`default_nettype none
module lpm_sequencer (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Avalon-MM slave
  input wire lpm_pkg::lpm_avs_req_t avs_req,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // CPU, break module and reset sources
  input wire lpm_pkg::lpm_cpu_t cpu,
  input wire lpm_pkg::lpm_rst_src_t rst_src,
  // Clock gating and core controls
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic core_clk_out_en,
  output logic osc_ref_clk_en,
  output logic stack_start,
  output logic clear_int_mask,
  output logic watchdog_run,
  output logic status_clear_ok,
  output lpm_pkg::lpm_state_t lp_state
);
  import lpm_pkg::*;

  // -----------------------------------------------------------------
  // State record
  // -----------------------------------------------------------------
  typedef struct packed {
    lpm_state_t st; // Power mode
    logic [LPM_CW-1:0] cnt; // Recovery counter
    logic stack; // Stacking start pulse
    logic imask; // Interrupt mask clear pulse
    logic brk; // break_exit_flag
    logic [7:0] cause; // Reset cause flags
    logic break_flag_clear_enable; // break_flag_clear_enable
    logic short_recovery_select; // short_recovery_select
    logic wdis; // watchdog_disable
    logic ack; // Bus answer armed
    logic [7:0] rdata; // Captured read data
  } lpm_regs_t;

  lpm_regs_t r_r; // Registered state
  lpm_regs_t r_nxt; // Next state

  // Last counter value of the chosen recovery
  function automatic logic [LPM_CW-1:0] rec_last(input logic short_sel);
    rec_last = short_sel ? LPM_CW'(LPM_REC_SHORT - 1)
                         : LPM_CW'(LPM_REC_LONG - 1);
  endfunction : rec_last

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------
  logic req; // Request present
  logic take; // Edge at which the request completes
  logic clr_ok; // Status clearing allowed now
  logic [7:0] rd_mux; // Read data before capture
  logic [7:0] ev_cause; // Cause events this cycle
  logic any_exit; // Reset source forces exit

  assign req = avs_req.read | avs_req.write;
  // Answer one cycle after the request; a frozen clock holds it off
  assign take = req & r_r.ack & clk_en;
  assign avs_waitrequest = req & ~take;
  assign avs_readdata = {24'h000000, r_r.rdata};
  assign clr_ok = r_r.break_flag_clear_enable | ~cpu.break_state;
  assign status_clear_ok = clr_ok;

  // Read multiplexer, unmapped offsets read as zero
  always_comb begin
    rd_mux = 8'h00;
    case (avs_req.address)
      LPM_OFS_BRK: rd_mux[LPM_BIT_BRK] = r_r.brk;
      LPM_OFS_CAUSE: rd_mux = r_r.cause;
      LPM_OFS_BFC: rd_mux[LPM_BIT_BREAK_FLAG_CLEAR_ENABLE] = r_r.break_flag_clear_enable;
      LPM_OFS_CFG: begin
        rd_mux[LPM_BIT_SHORT_RECOVERY_SELECT] = r_r.short_recovery_select;
        rd_mux[LPM_BIT_WDIS] = r_r.wdis;
      end
      default: rd_mux = 8'h00;
    endcase
  end

  // Reset source events; fetch flag only for opcode fetches
  always_comb begin
    ev_cause = 8'h00;
    ev_cause[LPM_BIT_PIN] = rst_src.pin;
    ev_cause[LPM_BIT_WDOG] = rst_src.wdog;
    ev_cause[LPM_BIT_OPC] = rst_src.opcode;
    ev_cause[LPM_BIT_FETCH] = rst_src.fetch & rst_src.opfetch;
    ev_cause[LPM_BIT_LV] = rst_src.lv;
  end
  assign any_exit = |ev_cause;

  // -----------------------------------------------------------------
  // Next-state logic
  // -----------------------------------------------------------------
  always_comb begin
    r_nxt = r_r;
    r_nxt.stack = 1'b0;
    r_nxt.imask = 1'b0;
    // Bus answer: arm after one wait cycle, drop once taken
    r_nxt.ack = req & ~r_r.ack;
    if (req & ~r_r.ack) begin
      r_nxt.rdata = avs_req.read ? rd_mux : 8'h00;
    end
    // Software writes, taken at the answering edge
    if (take & avs_req.write) begin
      case (avs_req.address)
        LPM_OFS_BRK: begin
          if (~avs_req.writedata[LPM_BIT_BRK] & clr_ok) begin
            r_nxt.brk = 1'b0;
          end
        end
        LPM_OFS_BFC: r_nxt.break_flag_clear_enable = avs_req.writedata[LPM_BIT_BREAK_FLAG_CLEAR_ENABLE];
        LPM_OFS_CFG: begin
          r_nxt.short_recovery_select = avs_req.writedata[LPM_BIT_SHORT_RECOVERY_SELECT];
          r_nxt.wdis = avs_req.writedata[LPM_BIT_WDIS];
        end
        default: r_nxt.break_flag_clear_enable = r_r.break_flag_clear_enable; // Unmapped writes ignored
      endcase
    end
    // Read clears only the flags that were returned
    if (take & avs_req.read & clr_ok &
        (avs_req.address == LPM_OFS_CAUSE)) begin
      r_nxt.cause = r_r.cause & ~r_r.rdata;
    end
    // A new reset source replaces the record; set beats clear
    if (any_exit) begin
      r_nxt.cause = ev_cause;
    end
    // Power mode sequencing
    case (r_r.st)
      LPM_RUN: begin
        r_nxt.cnt = r_r.cnt;
        if (cpu.stop_exec) begin
          r_nxt.st = LPM_STOP;
          r_nxt.cnt = '0;
          r_nxt.imask = 1'b1;
        end else if (cpu.wait_exec) begin
          r_nxt.st = LPM_WAIT;
          r_nxt.imask = 1'b1;
        end
      end
      LPM_WAIT: begin
        if (any_exit) begin
          r_nxt.st = LPM_RUN;
        end else if (cpu.break_irq) begin
          r_nxt.st = LPM_RUN;
          r_nxt.brk = 1'b1;
          r_nxt.stack = 1'b1;
        end else if (cpu.wake_irq) begin
          r_nxt.st = LPM_RUN;
          r_nxt.stack = 1'b1;
        end
      end
      LPM_STOP: begin
        r_nxt.cnt = '0;
        if (any_exit) begin
          r_nxt.st = LPM_RUN;
        end else if (cpu.break_irq | cpu.wake_irq) begin
          r_nxt.st = LPM_RECOVER;
          r_nxt.brk = r_r.brk | cpu.break_irq;
        end
      end
      LPM_RECOVER: begin
        // Counter times the oscillator settling window
        r_nxt.cnt = r_r.cnt + LPM_CW'(1);
        if (any_exit) begin
          r_nxt.st = LPM_RUN;
        end else if (r_r.cnt == rec_last(r_r.short_recovery_select)) begin
          r_nxt.st = LPM_RUN;
          r_nxt.stack = 1'b1;
        end
      end
      default: r_nxt.st = LPM_RUN;
    endcase
    // Frozen clock enable keeps everything
    if (!clk_en) begin
      r_nxt = r_r;
    end
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      r_r <= '0;
      r_r.st <= LPM_RUN;
      r_r.cause <= LPM_CAUSE_RST;
      r_r.break_flag_clear_enable <= LPM_BREAK_FLAG_CLEAR_ENABLE_RST;
      r_r.short_recovery_select <= LPM_SHORT_RECOVERY_SELECT_RST;
      r_r.wdis <= LPM_WDIS_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  // CPU clock off in both sleeps; peripherals keep light-sleep clock
  assign cpu_clk_en = (r_r.st == LPM_RUN);
  assign periph_clk_en = (r_r.st == LPM_RUN) | (r_r.st == LPM_WAIT);
  assign core_clk_out_en = (r_r.st == LPM_RUN) | (r_r.st == LPM_WAIT);
  // Reference clock must run again to time the recovery
  assign osc_ref_clk_en = (r_r.st != LPM_STOP);
  assign watchdog_run = ~r_r.wdis & (r_r.st != LPM_STOP) &
                        (r_r.st != LPM_RECOVER);
  assign stack_start = r_r.stack;
  assign clear_int_mask = r_r.imask;
  assign lp_state = r_r.st;

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_wait_irq;
    r_r.st == LPM_WAIT && cpu.wake_irq && !cpu.break_irq &&
    !any_exit && clk_en;
  endsequence
  sequence s_run_stack;
    r_r.st == LPM_RUN && stack_start;
  endsequence
  sequence s_rec_end;
    r_r.st == LPM_RECOVER && !any_exit && clk_en &&
    r_r.cnt == rec_last(r_r.short_recovery_select);
  endsequence

  AST_WAIT_CLOCKS: assert property (
    r_r.st == LPM_WAIT |-> !cpu_clk_en && periph_clk_en)
    else $error("light-sleep clock gating wrong");
  AST_WAIT_WAKE: assert property (
    s_wait_irq |=> s_run_stack)
    else $error("light-sleep wake did not stack next cycle");
  AST_BRK_EXIT: assert property (
    r_r.st inside {LPM_WAIT, LPM_STOP} && cpu.break_irq && !any_exit &&
    clk_en |=> r_r.brk && r_r.st != LPM_WAIT && r_r.st != LPM_STOP)
    else $error("break did not leave sleep with flag");
  AST_WDOG_WAIT: assert property (
    r_r.st == LPM_WAIT && !r_r.wdis |-> watchdog_run)
    else $error("watchdog stopped in light-sleep");
  AST_STOP_HALT: assert property (
    r_r.st == LPM_STOP |-> !core_clk_out_en && !osc_ref_clk_en &&
    r_r.cnt == '0 && !stack_start)
    else $error("deep-sleep left clocks or counter running");
  AST_REC_END: assert property (
    s_rec_end |=> s_run_stack)
    else $error("recovery end did not start stacking");
  AST_REC_HOLD: assert property (
    r_r.st == LPM_RECOVER |-> !stack_start &&
    r_r.cnt <= rec_last(r_r.short_recovery_select))
    else $error("stacking before recovery elapsed");
  AST_REC_COUNT: assert property (
    r_r.st == LPM_RECOVER && clk_en && !any_exit &&
    r_r.cnt != rec_last(r_r.short_recovery_select) |=> r_r.cnt == $past(r_r.cnt) + 1'b1)
    else $error("recovery counter did not advance");
  AST_CAUSE_CLR: assert property (
    take && avs_req.read && avs_req.address == LPM_OFS_CAUSE && clr_ok &&
    !any_exit |=> (r_r.cause & $past(r_r.rdata)) == 8'h00)
    else $error("cause flags not cleared by read");
  AST_BRK_GUARD: assert property (
    cpu.break_state && !r_r.break_flag_clear_enable && clk_en |=>
    (($past(r_r.cause) & ~r_r.cause) == 8'h00 || $past(any_exit)) &&
    (r_r.brk || !$past(r_r.brk)))
    else $error("status cleared during protected break");
  AST_IMASK: assert property (
    r_r.st == LPM_RUN && (cpu.wait_exec || cpu.stop_exec) && clk_en
    |=> clear_int_mask ##1 !clear_int_mask || !clk_en)
    else $error("sleep did not clear interrupt mask");

  // Reset sources win over wake requests in either sleep
  sequence s_sleep_reset;
    r_r.st inside {LPM_WAIT, LPM_STOP} && any_exit && clk_en;
  endsequence
  sequence s_run_quiet;
    r_r.st == LPM_RUN && !stack_start;
  endsequence
  sequence s_stop_wake;
    r_r.st == LPM_STOP && !any_exit && clk_en &&
    (cpu.wake_irq || cpu.break_irq);
  endsequence

  // Every clock runs while the core is awake
  AST_RUN_CLOCKS: assert property (
    r_r.st == LPM_RUN |-> cpu_clk_en && periph_clk_en &&
    core_clk_out_en && osc_ref_clk_en)
    else $error("clocks gated while running");
  // A reset source ends sleep with no vector fetch
  AST_SLEEP_RESET: assert property (
    s_sleep_reset |=> s_run_quiet)
    else $error("reset source did not end sleep cleanly");
  // Wake from deep sleep always passes through recovery
  AST_STOP_WAKE: assert property (
    s_stop_wake |=> r_r.st == LPM_RECOVER && r_r.cnt == '0)
    else $error("deep-sleep wake did not start recovery");
  // Counter starts from zero on deep-sleep entry
  AST_STOP_ENTRY: assert property (
    r_r.st == LPM_RUN && cpu.stop_exec && clk_en |=>
    r_r.st == LPM_STOP && r_r.cnt == '0)
    else $error("deep-sleep entry did not clear counter");
  // Cause record is replaced by the latest source only
  AST_CAUSE_SET: assert property (
    any_exit && clk_en |=> r_r.cause == $past(ev_cause))
    else $error("cause record does not match reset source");
  // Data fetches from holes never raise the fetch flag
  AST_FETCH_QUAL: assert property (
    clk_en && !(rst_src.fetch && rst_src.opfetch) |=>
    !r_r.cause[LPM_BIT_FETCH] || $past(r_r.cause[LPM_BIT_FETCH]))
    else $error("fetch flag set without an opcode fetch");
  // Awake, nothing can set the flag, so a zero write must clear it
  AST_BRK_CLEAR: assert property (
    take && avs_req.write && avs_req.address == LPM_OFS_BRK &&
    !avs_req.writedata[LPM_BIT_BRK] && clr_ok && r_r.st == LPM_RUN
    |=> !r_r.brk)
    else $error("break-exit flag not cleared by write of zero");

endmodule : lpm_sequencer
`default_nettype wire

/* File: lpm_cpu_model.sv */
// Model of the CPU core, interrupt sources and break module.
// Assumes the bench pulses cmd for one mclk cycle per event.
`timescale 1ns/10ps
`default_nettype none
module lpm_cpu_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bench commands: wait, stop, interrupt, break
  input wire logic [3:0] cmd,
  input wire logic brk_hold,
  // Answer from the sequencer
  input wire logic stack_start,
  // Requests to the sequencer
  output var lpm_pkg::lpm_cpu_t cpu
);
  import lpm_pkg::*;
  // ---------------------------------------------------------------
  // Request state
  // ---------------------------------------------------------------
  // Sources hold a request until stacking starts, as real ones do
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cpu <= '0;
    end else begin
      cpu.wait_exec <= cmd[3]; // One-cycle instruction strobe
      cpu.stop_exec <= cmd[2];
      cpu.break_state <= brk_hold;
      // Pending lines drop once stacking starts
      cpu.wake_irq <= cmd[1] | (cpu.wake_irq & ~stack_start);
      cpu.break_irq <= cmd[0] | (cpu.break_irq & ~stack_start);
    end
  end
endmodule : lpm_cpu_model
`default_nettype wire

/* File: tb_lpm.sv */
// Self-checking bench for the low-power sequencer and its registers.
// Assumes lpm_pkg, lpm_sequencer and lpm_cpu_model compile first.
`timescale 1ns/10ps
`default_nettype none
module tb;
  import lpm_pkg::*;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic mclk;
  logic rst_n;
  logic clk_en; // Held high except in t_freeze, which freezes the sequencer
  logic brk_hold; // Break state request to the model
  logic [3:0] cmd; // Model commands: wait, stop, irq, break
  lpm_avs_req_t avs_req;
  lpm_rst_src_t rst_src;
  lpm_cpu_t cpu;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, cpu_clk_en, periph_clk_en, core_clk_out_en;
  logic osc_ref_clk_en, stack_start, clear_int_mask, watchdog_run;
  logic status_clear_ok;
  lpm_state_t lp_state;
  int n_mismatch;
  int cmp_count;
  logic [7:0] q; // Last byte read
  lpm_sequencer dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en),
    .avs_req(avs_req), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu(cpu), .rst_src(rst_src),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
    .core_clk_out_en(core_clk_out_en), .osc_ref_clk_en(osc_ref_clk_en),
    .stack_start(stack_start), .clear_int_mask(clear_int_mask),
    .watchdog_run(watchdog_run), .status_clear_ok(status_clear_ok),
    .lp_state(lp_state));
  lpm_cpu_model cpu_u (.mclk(mclk), .rst_n(rst_n), .cmd(cmd),
    .brk_hold(brk_hold), .stack_start(stack_start), .cpu(cpu));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Compare and count
  task automatic chk(input string what, input logic [31:0] got,
                     input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One Avalon access; answer and read data taken at the same edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [7:0] d, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge mclk);
    avs_req <= '{read: !wr, write: wr, address: a, writedata: {24'h0, d}};
    @(posedge mclk);
    // Request held until the edge that sees waitrequest low
    while (avs_waitrequest !== 1'b0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk("bus_answer", avs_waitrequest, 1'b0);
    rd = avs_readdata[7:0];
    avs_req <= '0;
  endtask : bus
  // One-cycle command to the model
  task automatic pulse(input logic [3:0] c);
    @(posedge mclk);
    cmd <= c;
    @(posedge mclk);
    cmd <= 4'h0;
  endtask : pulse
  // Bounded wait for a sequencer state, seen at a negedge
  task automatic wait_state(input lpm_state_t s, input string what);
    int n;
    n = 0;
    @(negedge mclk);
    while (lp_state !== s && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    chk(what, lp_state, s);
  endtask : wait_state
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset values, read-clear and an unmapped address
  task automatic t_regs();
    bus(1'b0, LPM_OFS_CAUSE, 8'h00, q);
    chk("cause_por", q, 8'h80);
    bus(1'b0, LPM_OFS_CAUSE, 8'h00, q);
    chk("cause_cleared", q, 8'h00);
    bus(1'b0, LPM_OFS_BFC, 8'h00, q);
    chk("bfc_reset", q, 8'h00);
    bus(1'b0, LPM_OFS_CFG, 8'h00, q);
    chk("cfg_reset", q, 8'h00);
    bus(1'b0, 4'h2, 8'h00, q);
    chk("unmapped", q, 8'h00);
  endtask : t_regs
  // Light sleep left by an interrupt, watchdog option varied
  task automatic t_wait_irq(input logic wdis);
    bus(1'b1, LPM_OFS_CFG, {6'h0, wdis, 1'b0}, q);
    pulse(4'b1000);
    wait_state(LPM_WAIT, "wait_entry");
    chk("mask_clear", clear_int_mask, 1'b1);
    chk("cpu_clk_wait", cpu_clk_en, 1'b0);
    chk("periph_clk_wait", periph_clk_en, 1'b1);
    chk("wdog_wait", watchdog_run, !wdis);
    pulse(4'b0010);
    wait_state(LPM_RUN, "wait_exit");
    chk("stack_wait", stack_start, 1'b1);
    chk("cpu_clk_run", cpu_clk_en, 1'b1);
  endtask : t_wait_irq
  // Break ends light sleep; flag clears gated in break state
  task automatic t_wait_break();
    pulse(4'b1000);
    wait_state(LPM_WAIT, "wait_entry_b");
    pulse(4'b0001);
    wait_state(LPM_RUN, "wait_exit_b");
    @(posedge mclk);
    brk_hold <= 1'b1;
    bus(1'b0, LPM_OFS_BRK, 8'h00, q);
    chk("brk_flag_wait", q, 8'h02);
    chk("clear_blocked", status_clear_ok, 1'b0);
    bus(1'b1, LPM_OFS_BRK, 8'h00, q);
    bus(1'b0, LPM_OFS_BRK, 8'h00, q);
    chk("brk_flag_kept", q, 8'h02);
    bus(1'b1, LPM_OFS_BFC, 8'h80, q);
    // The enable lands at the answering edge; look once it settled
    @(negedge mclk);
    chk("clear_allowed", status_clear_ok, 1'b1);
    bus(1'b1, LPM_OFS_BRK, 8'h00, q);
    bus(1'b0, LPM_OFS_BRK, 8'h00, q);
    chk("brk_flag_clr", q, 8'h00);
    bus(1'b1, LPM_OFS_BFC, 8'h00, q);
    brk_hold <= 1'b0;
  endtask : t_wait_break
  // Deep sleep and recovery length, woken by irq or break
  task automatic t_stop(input logic shrt, input logic [3:0] wake,
                        input int n_rec);
    int n;
    bus(1'b1, LPM_OFS_CFG, {7'h0, shrt}, q);
    pulse(4'b0100);
    wait_state(LPM_STOP, "stop_entry");
    chk("core_clk_stop", core_clk_out_en, 1'b0);
    chk("osc_clk_stop", osc_ref_clk_en, 1'b0);
    pulse(wake);
    wait_state(LPM_RECOVER, "rec_entry");
    n = 0;
    while (lp_state === LPM_RECOVER && n < 5000) begin
      @(negedge mclk);
      n++;
    end
    chk("rec_length", n, n_rec);
    chk("stack_stop", stack_start, 1'b1);
    bus(1'b0, LPM_OFS_BRK, 8'h00, q);
    chk("brk_flag_stop", q, {6'h0, wake[0], 1'b0});
    bus(1'b1, LPM_OFS_BRK, 8'h00, q);
  endtask : t_stop
  // Each reset source and its cause flag
  task automatic t_causes();
    logic [5:0] src [6] = '{6'h20, 6'h10, 6'h08, 6'h06, 6'h04, 6'h01};
    logic [7:0] exp [6] = '{8'h40, 8'h20, 8'h10, 8'h08, 8'h00, 8'h02};
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      rst_src <= src[i];
      @(posedge mclk);
      rst_src <= '0;
      bus(1'b0, LPM_OFS_CAUSE, 8'h00, q);
      chk("cause_flag", q, exp[i]);
    end
  endtask : t_causes
  // Reset source ends light sleep without stacking
  task automatic t_wait_reset();
    pulse(4'b1000);
    wait_state(LPM_WAIT, "wait_entry_r");
    @(posedge mclk);
    rst_src <= 6'h20;
    @(posedge mclk);
    rst_src <= '0;
    wait_state(LPM_RUN, "wait_exit_r");
    chk("no_stack", stack_start, 1'b0);
    bus(1'b0, LPM_OFS_CAUSE, 8'h00, q);
    chk("cause_pin", q, 8'h40);
  endtask : t_wait_reset
  // Frozen enable holds light sleep; the wake lands once released
  task automatic t_freeze();
    pulse(4'b1000);
    wait_state(LPM_WAIT, "wait_entry_f");
    @(posedge mclk);
    clk_en <= 1'b0;
    pulse(4'b0010);
    repeat (4) @(negedge mclk);
    chk("frozen_wait", lp_state, LPM_WAIT);
    @(posedge mclk);
    clk_en <= 1'b1;
    wait_state(LPM_RUN, "freeze_exit");
    chk("stack_freeze", stack_start, 1'b1);
  endtask : t_freeze
  // Verdict and end of run
  task automatic wrap_up();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  // ---------------------------------------------------------------
  // Clock, watchdog, main sequence
  // ---------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // Run needs about 4300 cycles; cut off far beyond that
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    brk_hold = 1'b0;
    cmd = 4'h0;
    avs_req = '0;
    rst_src = '0;
    n_mismatch = 0;
    cmp_count = 0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_wait_irq(1'b0);
    t_wait_irq(1'b1);
    t_wait_break();
    t_stop(1'b1, 4'b0010, LPM_REC_SHORT);
    // Full delay, as a crystal-driven part keeps it
    t_stop(1'b0, 4'b0001, LPM_REC_LONG);
    t_causes();
    t_wait_reset();
    t_freeze();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
